// *** src/icache_consts.svh ***
// offsets, field positions and counts of the instruction cache
`ifndef ICACHE_CONSTS_SVH
`define ICACHE_CONSTS_SVH
`define IC_SEGMENTS 4
`define IC_SUBSEGS 8
`define IC_WORDS_PER_SUB 4
`define IC_TAG_WIDTH 22
`define IC_TAG_LSB 10
`define IC_SUB_LSB 7
`define IC_LONG_LSB 5
`define IC_HALF_BIT 4
`define IC_PC_ZERO_BITS 4
`endif

// *** src/icache_pkg.sv ***
// types of the instruction cache
package icache_pkg;
	typedef logic [1:0] seg_idx_t;
	typedef enum {ST_IDLE, ST_FILL, ST_ANSWER} fill_state_t;
endpackage : icache_pkg

// *** src/lru_stack.sv ***
// four-entry usage stack of 2-bit segment indices
`timescale 1ns/1ps
module lru_stack
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// control
	input wire logic clear_in,
	input wire logic touch_in,
	input wire icache_pkg::seg_idx_t touch_seg_in,
	// state
	output icache_pkg::seg_idx_t victim_out
);
	import icache_pkg::*;
	seg_idx_t stack_reg [0:3];
	logic [3:0] match;
	logic [3:0] shift_en;
	genvar g;
	// ****************************************
	// ordering
	// ****************************************
	generate
		for (g = 0; g < 4; g++)
		begin : gen_match
			assign match[g] = (stack_reg[g] == touch_seg_in);
		end
	endgenerate
	assign shift_en[0] = 1'b1;
	assign shift_en[1] = ~match[0];
	assign shift_en[2] = ~match[0] & ~match[1];
	assign shift_en[3] = ~match[0] & ~match[1] & ~match[2];
	assign victim_out = stack_reg[3];
	// RULE7 move to top
	generate
		for (g = 0; g < 4; g++)
		begin : gen_stack
			always_ff @(posedge sys_clk_in or negedge rstn_in)
			begin
				// RULE13 distinct reset order
				if (!rstn_in)
					stack_reg[g] <= seg_idx_t'(g);
				else if (clear_in)
					stack_reg[g] <= seg_idx_t'(g);
				else if (touch_in && shift_en[g])
					stack_reg[g] <= (g == 0) ? touch_seg_in : stack_reg[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate
endmodule : lru_stack

// *** src/instruction_cache_lru.sv ***
// four-segment instruction cache with usage-order replacement
//
// Behaviour
// RULE1 - 512 bytes held as four segments of 128 bytes.
// RULE2 - each segment has a 22-bit start address tag.
// RULE3 - eight subsegments per segment, four 32-bit long words each.
// RULE4 - each subsegment has its own present flag.
// RULE5 - memory is read only on a miss; hits make no memory access.
// RULE6 - a miss needing a new segment replaces the least recently used.
// RULE7 - usage order kept in a four-entry stack, most recent on top.
// RULE8 - each load fills exactly one whole subsegment.
// RULE9 - fetch addresses are bit addresses; low four bits read as zero.
// RULE10 - lookups, fills and replacement run with no software action.
// RULE11 - a host flush request invalidates every cached subsegment.
// RULE12 - a reassigned segment clears all its present flags before filling.
// RULE13 - after reset, flags clear and the stack holds each index once.
`include "icache_consts.svh"
`timescale 1ns/1ps
module instruction_cache_lru
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// host flush
	input wire logic host_control_high_flush_in,
	// instruction fetch
	input wire logic fetch_req_in,
	input wire logic [31:0] fetch_pc_in,
	output logic fetch_ack_out,
	output logic [15:0] fetch_word_out,
	// local memory fill
	output logic mem_req_out,
	output logic [31:0] mem_addr_out,
	input wire logic mem_valid_in,
	input wire logic [31:0] mem_data_in
);
	import icache_pkg::*;
	// halfword select of a long word
	function automatic logic [15:0] pick_half(input logic [31:0] long_word, input logic upper);
		return upper ? long_word[31:16] : long_word[15:0];
	endfunction : pick_half
	// ****************************************
	// storage
	// ****************************************
	// RULE1 data array
	logic [31:0] data_mem [0:`IC_SEGMENTS*`IC_SUBSEGS*`IC_WORDS_PER_SUB-1];
	// RULE2 segment tags
	logic [`IC_TAG_WIDTH-1:0] segment_tag_reg [0:`IC_SEGMENTS-1];
	logic [`IC_SEGMENTS-1:0] tag_valid_reg;
	// RULE4 present flags
	logic [`IC_SUBSEGS-1:0] present_reg [0:`IC_SEGMENTS-1];
	fill_state_t state_reg;
	logic [31:0] pc_reg;
	seg_idx_t fill_seg_reg;
	logic [1:0] word_cnt_reg;
	logic fetch_ack_reg;
	logic [15:0] fetch_word_reg;
	logic mem_req_reg;
	logic [31:0] mem_addr_reg;
	logic flush_s1_reg;
	logic flush_s2_reg;
	// ****************************************
	// lookup
	// ****************************************
	// RULE9 low bits forced zero
	wire [31:0] pc_aligned = {fetch_pc_in[31:`IC_PC_ZERO_BITS], 4'h0};
	wire [`IC_TAG_WIDTH-1:0] req_tag = pc_aligned[31:`IC_TAG_LSB];
	wire [2:0] req_sub = pc_aligned[`IC_TAG_LSB-1:`IC_SUB_LSB];
	wire [1:0] req_long = pc_aligned[`IC_SUB_LSB-1:`IC_LONG_LSB];
	wire req_half = pc_aligned[`IC_HALF_BIT];
	logic [`IC_SEGMENTS-1:0] tag_hit;
	genvar g;
	generate
		for (g = 0; g < `IC_SEGMENTS; g++)
		begin : gen_cmp
			assign tag_hit[g] = tag_valid_reg[g] && (segment_tag_reg[g] == req_tag);
		end
	endgenerate
	wire any_tag_hit = |tag_hit;
	wire seg_idx_t hit_seg = tag_hit[3] ? 2'h3 : tag_hit[2] ? 2'h2 : tag_hit[1] ? 2'h1 : 2'h0;
	wire seg_idx_t victim;
	// RULE6 pick oldest segment
	wire seg_idx_t use_seg = any_tag_hit ? hit_seg : victim;
	wire sub_present = any_tag_hit && present_reg[hit_seg][req_sub];
	wire idle = (state_reg == ST_IDLE);
	wire start = idle && fetch_req_in && !flush_s2_reg;
	// RULE5 hit served locally
	wire hit = start && sub_present;
	wire miss = start && !sub_present;
	wire fill_done = (state_reg == ST_FILL) && mem_valid_in && (word_cnt_reg == 2'h3);
	wire [6:0] fill_index = {fill_seg_reg, pc_reg[`IC_TAG_LSB-1:`IC_SUB_LSB], word_cnt_reg};
	wire [6:0] hit_index = {hit_seg, req_sub, req_long};
	wire [6:0] ans_index = {fill_seg_reg, pc_reg[`IC_TAG_LSB-1:`IC_LONG_LSB]};
	wire [31:0] hit_long = data_mem[hit_index];
	wire [31:0] ans_long = data_mem[ans_index];
	wire [15:0] hit_half_word = pick_half(hit_long, req_half);
	wire [15:0] ans_half_word = pick_half(ans_long, pc_reg[`IC_HALF_BIT]);
	// RULE7 touch on each use
	lru_stack u_lru
	(
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.clear_in(flush_s2_reg),
		.touch_in(hit || miss),
		.touch_seg_in(use_seg),
		.victim_out(victim)
	);
	// ****************************************
	// flush synchroniser
	// ****************************************
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			flush_s1_reg <= 1'b0;
			flush_s2_reg <= 1'b0;
		end
		else
		begin
			flush_s1_reg <= host_control_high_flush_in;
			flush_s2_reg <= flush_s1_reg;
		end
	end
	// ****************************************
	// data array write
	// ****************************************
	// RULE3 four long words per subsegment
	always_ff @(posedge sys_clk_in)
	begin
		if ((state_reg == ST_FILL) && mem_valid_in)
			data_mem[fill_index] <= mem_data_in;
	end
	// ****************************************
	// tags and present flags
	// ****************************************
	generate
		for (g = 0; g < `IC_SEGMENTS; g++)
		begin : gen_seg
			always_ff @(posedge sys_clk_in or negedge rstn_in)
			begin
				// RULE13 flags clear at reset
				if (!rstn_in)
				begin
					segment_tag_reg[g] <= '0;
					tag_valid_reg[g] <= 1'b0;
					present_reg[g] <= '0;
				end
				// RULE11 flush invalidates all
				else if (flush_s2_reg)
				begin
					tag_valid_reg[g] <= 1'b0;
					present_reg[g] <= '0;
				end
				// RULE12 reassign clears flags
				else if (miss && !any_tag_hit && (victim == seg_idx_t'(g)))
				begin
					segment_tag_reg[g] <= req_tag;
					tag_valid_reg[g] <= 1'b1;
					present_reg[g] <= '0;
				end
				// RULE8 whole subsegment marked
				else if (fill_done && (fill_seg_reg == seg_idx_t'(g)))
					present_reg[g][pc_reg[`IC_TAG_LSB-1:`IC_SUB_LSB]] <= 1'b1;
			end
		end
	endgenerate
	// ****************************************
	// control
	// ****************************************
	// RULE10 automatic sequencing
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_reg <= ST_IDLE;
			pc_reg <= '0;
			fill_seg_reg <= '0;
			word_cnt_reg <= '0;
			fetch_ack_reg <= 1'b0;
			fetch_word_reg <= '0;
			mem_req_reg <= 1'b0;
			mem_addr_reg <= '0;
		end
		else
		begin
			fetch_ack_reg <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (hit)
					begin
						fetch_ack_reg <= 1'b1;
						fetch_word_reg <= hit_half_word;
					end
					else if (miss)
					begin
						pc_reg <= pc_aligned;
						fill_seg_reg <= use_seg;
						word_cnt_reg <= 2'h0;
						mem_req_reg <= 1'b1;
						mem_addr_reg <= {pc_aligned[31:`IC_SUB_LSB], 7'h00};
						state_reg <= ST_FILL;
					end
				end
				ST_FILL:
				begin
					if (mem_valid_in)
					begin
						word_cnt_reg <= word_cnt_reg + 2'h1;
						mem_addr_reg <= mem_addr_reg + 32'h00000020;
						if (word_cnt_reg == 2'h3)
						begin
							mem_req_reg <= 1'b0;
							state_reg <= ST_ANSWER;
						end
					end
				end
				ST_ANSWER:
				begin
					fetch_ack_reg <= 1'b1;
					fetch_word_reg <= ans_half_word;
					state_reg <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end
	assign fetch_ack_out = fetch_ack_reg;
	assign fetch_word_out = fetch_word_reg;
	assign mem_req_out = mem_req_reg;
	assign mem_addr_out = mem_addr_reg;
endmodule : instruction_cache_lru

// *** verification/icache_props.sv ***
// port assertions of the instruction cache
`timescale 1ns/1ps
module icache_props
(
	// ports watched
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic host_control_high_flush_in,
	input wire logic fetch_req_in,
	input wire logic fetch_ack_out,
	input wire logic mem_req_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic mem_valid_in
);
	logic [2:0] word_cnt;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence word_taken;
		mem_req_out && mem_valid_in;
	endsequence
	sequence flush_held;
		host_control_high_flush_in [*3];
	endsequence
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			word_cnt <= 3'h0;
		else if (!mem_req_out)
			word_cnt <= 3'h0;
		else if (mem_valid_in)
			word_cnt <= word_cnt + 3'h1;
	end
	a_fill_needs_fetch: assert property ($rose(mem_req_out) |-> $past(fetch_req_in))
		else $error("fill started without fetch");
	a_fill_four_words: assert property ($fell(mem_req_out) |-> word_cnt == 3'h4)
		else $error("fill length wrong");
	a_fill_base_aligned: assert property ($rose(mem_req_out) |-> mem_addr_out[6:0] == 7'h00)
		else $error("fill base not subsegment");
	a_addr_step_long: assert property (word_taken ##0 word_cnt < 3'h3
		|=> mem_addr_out == $past(mem_addr_out) + 32'h20)
		else $error("fill address step wrong");
	a_miss_answer: assert property ($fell(mem_req_out) |=> fetch_ack_out)
		else $error("no answer after fill");
	a_no_ack_filling: assert property (mem_req_out |-> !fetch_ack_out)
		else $error("answer during fill");
	a_ack_one_cycle: assert property (fetch_ack_out && !fetch_req_in |=> !fetch_ack_out)
		else $error("answer longer than a cycle");
	a_flush_blocks: assert property (flush_held ##0 !mem_req_out |=> !mem_req_out)
		else $error("fill taken while flushing");
endmodule : icache_props

// *** verification/mem_model.sv ***
// local-memory model answering subsegment fills
`timescale 1ns/1ps
module mem_model
(
	// clock and pacing
	input wire logic sys_clk_in,
	input wire logic slow_in,
	// fill request
	input wire logic req_in,
	input wire logic [31:0] addr_in,
	// fill answer
	output logic valid_out,
	output logic [31:0] data_out
);
	logic stall = 1'b0;
	initial
	begin
		valid_out = 1'b0;
		data_out = 32'h0;
	end
	always @(posedge sys_clk_in)
	begin
		#1;
		stall = slow_in & ~stall;
		valid_out = req_in & ~stall;
		data_out = valid_out ? {addr_in[20:5], ~addr_in[20:5]} : ~data_out;
	end
endmodule : mem_model

// *** verification/instruction_cache_lru_tb_top.sv ***
// testbench of the instruction cache
`timescale 1ns/1ps
module instruction_cache_lru_tb_top;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic flush = 1'b0;
	logic req = 1'b0;
	logic slow = 1'b0;
	logic [31:0] pc = 32'h0;
	logic fetch_ack_out;
	logic mem_req_out;
	logic mem_valid_in;
	logic [15:0] fetch_word_out;
	logic [31:0] mem_addr_out;
	logic [31:0] mem_data_in;
	int error_cnt = 0;
	int checks = 0;
	int words = 0;
	always #50 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (mem_req_out && mem_valid_in) words++;
	instruction_cache_lru dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.host_control_high_flush_in(flush), .fetch_req_in(req), .fetch_pc_in(pc),
		.fetch_ack_out(fetch_ack_out), .fetch_word_out(fetch_word_out),
		.mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
		.mem_valid_in(mem_valid_in), .mem_data_in(mem_data_in));
	mem_model mem_u (.sys_clk_in(sys_clk_in), .slow_in(slow), .req_in(mem_req_out),
		.addr_in(mem_addr_out), .valid_out(mem_valid_in), .data_out(mem_data_in));
	task conclude;
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task fetch(input logic [31:0] a, input int fills);
		int w0;
		int n;
		w0 = words;
		@(posedge sys_clk_in);
		#1;
		req = 1'b1;
		pc = a;
		n = 0;
		do
		begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end while (fetch_ack_out !== 1'b1 && n < 40);
		req = 1'b0;
		chk({31'h0, fetch_ack_out}, 32'h1);
		chk({16'h0, fetch_word_out}, {16'h0, a[4] ? a[20:5] : ~a[20:5]});
		chk(32'(words - w0), 32'(fills));
	endtask : fetch
	task t_reset;
		chk({31'h0, mem_req_out}, 32'h0);
		chk({15'h0, fetch_ack_out, fetch_word_out}, 32'h0);
	endtask : t_reset
	task t_miss_hit;
		slow = 1'b1;
		fetch(32'h0000040F, 4);
		fetch(32'h00000410, 0);
		fetch(32'h00000460, 0);
		fetch(32'h00000490, 4);
		slow = 1'b0;
	endtask : t_miss_hit
	task t_lru;
		fetch(32'h00000800, 4);
		fetch(32'h00000C00, 4);
		fetch(32'h00001000, 4);
		fetch(32'h00001400, 4);
		fetch(32'h00001480, 4);
		fetch(32'h00000400, 4);
		fetch(32'h00000C10, 0);
		fetch(32'h00000800, 4);
	endtask : t_lru
	task t_flush;
		flush = 1'b1;
		repeat (2) @(posedge sys_clk_in);
		fork
			begin
				repeat (2) @(posedge sys_clk_in);
				#1;
				flush = 1'b0;
			end
			fetch(32'h00000C00, 4);
		join
		fetch(32'h00000C10, 0);
	endtask : t_flush
	task t_mid_reset;
		@(posedge sys_clk_in);
		#1;
		rstn_in = 1'b0;
		repeat (2) @(posedge sys_clk_in);
		#1;
		rstn_in = 1'b1;
		t_reset;
		fetch(32'h00000C10, 4);
		fetch(32'h00001800, 4);
		fetch(32'h00001C00, 4);
		fetch(32'h00002000, 4);
		fetch(32'h00000C00, 0);
	endtask : t_mid_reset
	initial
	begin
		repeat (2) @(posedge sys_clk_in);
		#1;
		rstn_in = 1'b1;
		t_reset;
		t_miss_hit;
		t_lru;
		t_flush;
		t_mid_reset;
		conclude;
	end
	initial
	begin
		#200000;
		error_cnt++;
		conclude;
	end
endmodule : instruction_cache_lru_tb_top
bind instruction_cache_lru icache_props chk_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.host_control_high_flush_in(host_control_high_flush_in), .fetch_req_in(fetch_req_in),
	.fetch_ack_out(fetch_ack_out), .mem_req_out(mem_req_out),
	.mem_addr_out(mem_addr_out), .mem_valid_in(mem_valid_in));
